// >>> rtl/pac_port.sv
// Behaviour
// - bits 7,6,4,3,0 each selectable input or push-pull output with selectable pull-high
// - bit 5 is input or open-drain output only; its other use is reset
// - bit 5 never gets a pull-high, whatever the pull register says
// - any pin change wakes from sleep unless its wake-enable bit is zero
// - bit 0 as interrupt line raises a request on rising and falling edges
`timescale 1ns/100ps
module pac_port
	import pac_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	output logic [7:0] pin_pull_en,
	// core side events
	output logic ext_irq_line_zero,
	output logic wake_req,
	output logic ext_hw_reset_n,
	output logic irq
);

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] pull;
		logic [7:0] wake;
		logic [7:0] mask;
		logic [7:0] ctrl;
		logic [1:0] stat;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [7:0] pout;
		logic [7:0] poe_n;
		logic [7:0] ppull;
		logic irq_pulse;
		logic wake_pulse;
		logic rst_n;
		logic irq_out;
	} pac_state_s;

	pac_state_s s_q;
	pac_state_s s_d;

	function automatic logic [31:0] pac_byte(input logic [7:0] b);
		pac_byte = {24'h00_0000, b};
	endfunction : pac_byte

	// register map lookup, shared by the bus decode and its checks
	function automatic logic pac_mapped(input logic [7:0] a, input logic wr);
		unique case (a)
			PAC_OFF_DATA, PAC_OFF_DIR, PAC_OFF_PULL, PAC_OFF_WAKE: pac_mapped = 1'b1;
			PAC_OFF_STAT, PAC_OFF_MASK, PAC_OFF_CTRL: pac_mapped = 1'b1;
			PAC_OFF_PIN: pac_mapped = !wr;
			default: pac_mapped = 1'b0;
		endcase
	endfunction : pac_mapped

	logic setup;
	logic access;
	logic [7:0] changed;
	logic edge_ev;
	logic wake_ev;
	logic [7:0] pins_oe;

	always_comb begin
		setup = psel && !penable;
		access = psel && penable && s_q.ready;
		changed = s_q.sync2 ^ s_q.prev;
		edge_ev = s_q.ctrl[PAC_CT_IRQEN] && changed[PAC_BIT_ZERO];
		wake_ev = s_q.ctrl[PAC_CT_SLEEP] && |(changed & s_q.wake & PAC_PORT_MASK);
		pins_oe = s_q.dir & PAC_PIN_MASK;
	end

	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin_in;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		s_d.irq_pulse = edge_ev;
		s_d.wake_pulse = wake_ev;
		s_d.ready = setup;
		s_d.err = setup && !pac_mapped(paddr, pwrite);
		s_d.rdata = PAC_ZERO_WORD;
		if (setup && !pwrite) begin
			unique case (paddr)
				PAC_OFF_DATA: s_d.rdata = pac_byte(s_q.data);
				PAC_OFF_DIR: s_d.rdata = pac_byte(s_q.dir);
				PAC_OFF_PULL: s_d.rdata = pac_byte(s_q.pull);
				PAC_OFF_WAKE: s_d.rdata = pac_byte(s_q.wake);
				PAC_OFF_PIN: s_d.rdata = pac_byte(s_q.sync2);
				PAC_OFF_STAT: s_d.rdata = {30'h0, s_q.stat};
				PAC_OFF_MASK: s_d.rdata = pac_byte(s_q.mask);
				PAC_OFF_CTRL: s_d.rdata = pac_byte(s_q.ctrl);
				default: s_d.rdata = PAC_ZERO_WORD;
			endcase
		end
		if (access && pwrite) begin
			unique case (paddr)
				PAC_OFF_DATA: s_d.data = pwdata[7:0];
				PAC_OFF_DIR: s_d.dir = pwdata[7:0];
				PAC_OFF_PULL: s_d.pull = pwdata[7:0];
				PAC_OFF_WAKE: s_d.wake = pwdata[7:0];
				PAC_OFF_MASK: s_d.mask = pwdata[7:0];
				PAC_OFF_CTRL: s_d.ctrl = pwdata[7:0];
				default: s_d.data = s_q.data;
			endcase
		end
		// clear only what the read reported, an event after the setup edge survives
		if (access && !pwrite && paddr == PAC_OFF_STAT)
			s_d.stat = s_q.stat & ~s_q.rdata[1:0];
		// set wins over read clear
		if (edge_ev)
			s_d.stat[PAC_ST_EDGE] = 1'b1;
		if (wake_ev)
			s_d.stat[PAC_ST_WAKE] = 1'b1;
		// push-pull bits drive both levels, bit 5 only pulls low
		s_d.pout = s_q.data & pins_oe;
		s_d.poe_n = ~pins_oe;
		s_d.pout[PAC_BIT_FIVE] = 1'b0;
		s_d.poe_n[PAC_BIT_FIVE] = !(s_q.dir[PAC_BIT_FIVE] && !s_q.data[PAC_BIT_FIVE]);
		s_d.ppull = s_q.pull & PAC_PIN_MASK;
		s_d.ppull[PAC_BIT_FIVE] = 1'b0;
		s_d.rst_n = !(s_q.ctrl[PAC_CT_RSTEN] && !s_q.sync2[PAC_BIT_FIVE]);
		s_d.irq_out = |(s_d.stat & s_q.mask[1:0]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.wake <= PAC_RST_WAKE;
			s_q.poe_n <= PAC_RST_OE;
			s_q.rst_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		prdata = s_q.rdata;
		pready = s_q.ready;
		pslverr = s_q.err;
		pin_out = s_q.pout;
		pin_oe_n = s_q.poe_n;
		pin_pull_en = s_q.ppull;
		ext_irq_line_zero = s_q.irq_pulse;
		wake_req = s_q.wake_pulse;
		ext_hw_reset_n = s_q.rst_n;
		irq = s_q.irq_out;
	end

	a_bit5_no_high: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_oe_n[PAC_BIT_FIVE] |-> !pin_out[PAC_BIT_FIVE])
		else $error("bit five driven high");
	a_bit5_no_pull: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_pull_en[PAC_BIT_FIVE])
		else $error("bit five pull enabled");
	a_edge_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.ctrl[PAC_CT_IRQEN] && $changed(s_q.sync2[PAC_BIT_ZERO]))
		|=> ext_irq_line_zero)
		else $error("bit zero edge gave no request");
	a_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		ext_irq_line_zero |-> $past(s_q.prev[PAC_BIT_ZERO]) != $past(s_q.sync2[PAC_BIT_ZERO])
		&& $past(s_q.ctrl[PAC_CT_IRQEN]))
		else $error("request without edge");
	a_wake_gated: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req |-> |($past(changed) & $past(s_q.wake) & PAC_PORT_MASK))
		else $error("wake from disabled pin");
	a_push_pull: assert property (@(posedge pclk) disable iff (!presetn)
		$past(s_q.dir[PAC_BIT_ZERO]) |-> !pin_oe_n[PAC_BIT_ZERO]
		&& pin_out[PAC_BIT_ZERO] == $past(s_q.data[PAC_BIT_ZERO]))
		else $error("bit zero not driven");

	// bus handshake

	a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
		pready
		|=> !pready)
		else $error("ready held too long");

	a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		pready
		|-> $past(setup))
		else $error("ready without setup");

	a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr
		|-> pready)
		else $error("error without ready");

	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		$past(setup && !pac_mapped(paddr, pwrite))
		|-> pslverr)
		else $error("unmapped access not refused");

	a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready
		|-> prdata == PAC_ZERO_WORD)
		else $error("read data outside transfer");

	a_err_no_data: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr
		|-> prdata == PAC_ZERO_WORD)
		else $error("refused read returned data");

	a_write_data: assert property (@(posedge pclk) disable iff (!presetn)
		$past(access && pwrite && paddr == PAC_OFF_DATA)
		|-> s_q.data == $past(pwdata[7:0]))
		else $error("data write lost");

	a_write_dir: assert property (@(posedge pclk) disable iff (!presetn)
		$past(access && pwrite && paddr == PAC_OFF_DIR)
		|-> s_q.dir == $past(pwdata[7:0]))
		else $error("direction write lost");

	a_write_wake: assert property (@(posedge pclk) disable iff (!presetn)
		$past(access && pwrite && paddr == PAC_OFF_WAKE)
		|-> s_q.wake == $past(pwdata[7:0]))
		else $error("wake enable write lost");

	a_pin_readback: assert property (@(posedge pclk) disable iff (!presetn)
		$past(setup && !pwrite && paddr == PAC_OFF_PIN)
		|-> prdata == pac_byte($past(s_q.sync2)))
		else $error("pin read not synchronised value");

	// pin drivers

	a_out_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(pin_out & PAC_PIN_MASK)
		== ($past(s_q.data) & $past(s_q.dir) & PAC_PIN_MASK))
		else $error("push-pull level wrong");

	a_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(pin_oe_n & PAC_PIN_MASK)
		== (~$past(s_q.dir) & PAC_PIN_MASK))
		else $error("push-pull enable wrong");

	a_pull_follow: assert property (@(posedge pclk) disable iff (!presetn)
		pin_pull_en
		== ($past(s_q.pull) & PAC_PIN_MASK))
		else $error("pull-high select wrong");

	a_unused_idle: assert property (@(posedge pclk) disable iff (!presetn)
		pin_oe_n[2:1] == 2'b11
		&& pin_out[2:1] == 2'b00)
		else $error("missing pins driven");

	a_bit5_release: assert property (@(posedge pclk) disable iff (!presetn)
		$past(s_q.dir[PAC_BIT_FIVE]) && $past(s_q.data[PAC_BIT_FIVE])
		|-> pin_oe_n[PAC_BIT_FIVE])
		else $error("bit five not released");

	a_bit5_sink: assert property (@(posedge pclk) disable iff (!presetn)
		$past(s_q.dir[PAC_BIT_FIVE]) && !$past(s_q.data[PAC_BIT_FIVE])
		|-> !pin_oe_n[PAC_BIT_FIVE])
		else $error("bit five not pulled low");

	a_reset_pin: assert property (@(posedge pclk) disable iff (!presetn)
		ext_hw_reset_n
		== !($past(s_q.ctrl[PAC_CT_RSTEN]) && !$past(s_q.sync2[PAC_BIT_FIVE])))
		else $error("reset input not followed");

	// events and status

	a_sync_chain: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.sync2
		== $past(s_q.sync1))
		else $error("synchroniser skipped");

	a_stat_edge_set: assert property (@(posedge pclk) disable iff (!presetn)
		edge_ev
		|=> s_q.stat[PAC_ST_EDGE])
		else $error("edge status lost");

	a_stat_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
		wake_ev
		|=> s_q.stat[PAC_ST_WAKE])
		else $error("wake status lost");

	a_stat_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_q.stat[PAC_ST_EDGE])
		|-> $past(access && !pwrite && paddr == PAC_OFF_STAT))
		else $error("edge status dropped without read");

	a_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req
		|-> $past(s_q.ctrl[PAC_CT_SLEEP]))
		else $error("wake while awake");

	a_wake_fires: assert property (@(posedge pclk) disable iff (!presetn)
		wake_ev
		|=> wake_req)
		else $error("enabled pin change gave no wake");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		irq
		== |(s_q.stat & $past(s_q.mask[1:0])))
		else $error("interrupt level wrong");
endmodule : pac_port

// >>> rtl/pac_pkg.sv
package pac_pkg;
	// register byte offsets
	localparam logic [7:0] PAC_OFF_DATA = 8'h00;
	localparam logic [7:0] PAC_OFF_DIR = 8'h04;
	localparam logic [7:0] PAC_OFF_PULL = 8'h08;
	localparam logic [7:0] PAC_OFF_WAKE = 8'h0C;
	localparam logic [7:0] PAC_OFF_PIN = 8'h10;
	localparam logic [7:0] PAC_OFF_STAT = 8'h14;
	localparam logic [7:0] PAC_OFF_MASK = 8'h18;
	localparam logic [7:0] PAC_OFF_CTRL = 8'h1C;
	// port bit layout
	localparam logic [7:0] PAC_PIN_MASK = 8'hD9;
	localparam logic [7:0] PAC_PORT_MASK = 8'hF9;
	localparam int PAC_BIT_ZERO = 0;
	localparam int PAC_BIT_FIVE = 5;
	// reset values
	localparam logic [7:0] PAC_RST_BYTE = 8'h00;
	localparam logic [7:0] PAC_RST_WAKE = 8'hFF;
	localparam logic [7:0] PAC_RST_OE = 8'hFF;
	// status bit layout
	localparam int PAC_ST_EDGE = 0;
	localparam int PAC_ST_WAKE = 1;
	// control bit layout
	localparam int PAC_CT_IRQEN = 0;
	localparam int PAC_CT_SLEEP = 1;
	localparam int PAC_CT_RSTEN = 2;
	localparam logic [31:0] PAC_ZERO_WORD = 32'h0000_0000;
endpackage : pac_pkg

// >>> tb/pac_board.sv
`timescale 1ns/100ps
module pac_board (
	// design side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pin_pull_en,
	// bench side
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_in
);
	// floating pins go high by pull, else show the inverse of pin_out
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pin_pull_en | ~pin_out));
endmodule : pac_board

// >>> tb/port_a_pin_control_test.sv
`timescale 1ns/100ps
module port_a_pin_control_test;
	import pac_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic ext_irq_line_zero, wake_req, ext_hw_reset_n, irq;
	logic [7:0] paddr, ext_val, ext_en, pin_in, pin_out, pin_oe_n, pin_pull_en;
	logic [31:0] pwdata, prdata, rd;
	int mismatches, total_checks, edges, wakes, e0;
	logic [7:0] rows [6][3] = '{'{PAC_OFF_DATA, 8'h00, 8'h00}, '{PAC_OFF_PULL, 8'hF9, 8'hF9},
		'{PAC_OFF_MASK, 8'h01, 8'h01}, '{PAC_OFF_WAKE, 8'hF7, 8'hF7},
		'{PAC_OFF_DIR, 8'hFF, 8'hFF}, '{PAC_OFF_CTRL, 8'h01, 8'h01}};
	pac_port u_pac_port (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.pin_pull_en(pin_pull_en),
		.ext_irq_line_zero(ext_irq_line_zero),
		.wake_req(wake_req),
		.ext_hw_reset_n(ext_hw_reset_n),
		.irq(irq)
	);
	pac_board u_pac_board (
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.pin_pull_en(pin_pull_en),
		.ext_val(ext_val),
		.ext_en(ext_en),
		.pin_in(pin_in)
	);
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		edges <= edges + ext_irq_line_zero;
		wakes <= wakes + wake_req;
	end
	task print_verdict;
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	initial begin
		#100us;
		mismatches++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ext_val} = '0;
		{edges, wakes, mismatches, total_checks} = '0;
		ext_en = 8'hFF;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		check(pin_oe_n, 8'hFF);
		check(ext_hw_reset_n, 1);
		apb(0, PAC_OFF_WAKE, 0);
		check(rd, 32'hFF);
		foreach (rows[i]) begin
			apb(1, rows[i][0], rows[i][1]);
			apb(0, rows[i][0], 0);
			check(rd, rows[i][2]);
		end
		check(pin_oe_n, 8'h06);
		check(pin_in[5], 0);
		check(pin_pull_en[5], 0);
		check(pin_pull_en[7], 1);
		apb(1, PAC_OFF_DATA, 8'hFF);
		repeat (2) @(posedge pclk);
		check(pin_out, 8'hD9);
		check(pin_oe_n, 8'h26);
		apb(0, PAC_OFF_PIN, 0);
		check(rd, 32'hD9);
		apb(1, PAC_OFF_DATA, 8'h00);
		repeat (4) @(posedge pclk);
		apb(1, PAC_OFF_DIR, 0);
		e0 = edges;
		ext_val[0] <= 1;
		repeat (8) @(posedge pclk);
		ext_val[0] <= 0;
		repeat (8) @(posedge pclk);
		check(edges - e0, 2);
		check(irq, 1);
		apb(0, PAC_OFF_STAT, 0);
		check(rd, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 0);
		apb(1, PAC_OFF_CTRL, 8'h02);
		e0 = wakes;
		ext_val[3] <= 1;
		repeat (8) @(posedge pclk);
		check(wakes - e0, 0);
		ext_val[4] <= 1;
		repeat (8) @(posedge pclk);
		check(wakes - e0, 1);
		ext_val[5] <= 1;
		repeat (8) @(posedge pclk);
		check(wakes - e0, 2);
		ext_val[5] <= 0;
		repeat (8) @(posedge pclk);
		check(wakes - e0, 3);
		apb(1, PAC_OFF_CTRL, 8'h04);
		repeat (4) @(posedge pclk);
		check(ext_hw_reset_n, 0);
		apb(0, 8'h20, 0);
		check(err, 1);
		check(rd, 0);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		check(ext_hw_reset_n, 1);
		check(pin_oe_n, 8'hFF);
		apb(0, PAC_OFF_WAKE, 0);
		check(rd, 32'hFF);
		print_verdict();
	end
endmodule : port_a_pin_control_test
